// ==== tcc_consts.svh ====
// Register offsets, field positions and reset values of the timer control block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_OFF_SYS_CONTROL_ONE 8'hC6
`define TCC_OFF_COMPARE_OUTPUT_CONTROL 8'hC8
`define TCC_OFF_CAPTURE_EDGE_CONTROL 8'hC9
`define TCC_OFF_CHANNEL_INTERRUPT_ENABLE 8'hCA
`define TCC_OFF_SYSTEM_CONTROL_TWO 8'hCB
`define TCC_OFF_CHANNEL_EVENT_FLAGS 8'hCC
`define TCC_OFF_OVERFLOW_FLAG 8'hCD

`define TCC_BIT_RUN_ENABLE 7
`define TCC_BIT_FAST_FLAG_CLEAR 4
`define TCC_BIT_OVERFLOW_IRQ_ENABLE 7
`define TCC_BIT_COUNTER_RESET_ON_CH3 3
`define TCC_BIT_OVERFLOW_FLAG 7

`define TCC_MASK_SYS_CONTROL_ONE 8'h90
`define TCC_MASK_SYSTEM_CONTROL_TWO 8'h8F
`define TCC_MASK_CHANNELS 8'h0F
`define TCC_MASK_OVERFLOW_FLAG 8'h80

`define TCC_RESET_REG 8'h00
`define TCC_COUNT_MAX 16'hFFFF
`define TCC_COUNT_ZERO 16'h0000
`define TCC_PRESC_FULL 7'h7F
`define TCC_PRESC_ZERO 7'h00

`endif

// ==== tcc_pkg.sv ====
// Types shared by the timer control block
package tcc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcc_bus_req_s;

  typedef enum logic [1:0] {
    ACT_OFF = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } tcc_action_e;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3
  } tcc_edge_e;

  typedef logic [15:0] tcc_count_t;
endpackage

// ==== tcc_timer_ctrl.sv ====
// Four-channel timer control, prescaler, counter, flags and register port
//
// Overview of operation
// - Each channel has an action mode bit (odd) and level bit (even).
// - Compare action: 00 disconnect, 01 toggle, 10 drive low, 11 drive high.
// - Any nonzero action code makes the channel pin a driven output.
// - Action bits steer the compare output line only while that channel's ch3CompareMask bit is clear.
// - Edge field: 00 off, 01 rising, 10 falling, 11 either edge captures.
// - Channel flag raises an interrupt request only while its enable is set.
// - Overflow flag raises an interrupt request only while overflow enable is set.
// - Counter reset enable clears the counter on a channel 3 compare.
// - Reset enabled with channel 3 value zero holds the counter at zero.
// - Reset enabled with channel 3 value all ones sets no overflow.
// - Timer clock is bus clock divided by two to the prescale select.
// - New prescale applies only when all prescaler stages are zero.
// - Capture or compare event on a channel sets its event flag.
// - Writing one clears a channel flag; writing zero leaves it.
// - Fast clear: capture read or compare write clears that channel flag.
// - Counter wrap from all ones to zero sets the overflow flag.
// - Writing one to the overflow flag clears it.
// - Fast clear: any counter access clears the overflow flag.
// - Timer runs only while the run enable bit is set.
`timescale 1ns/1ns
`include "tcc_consts.svh"

module tcc_timer_ctrl import tcc_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire tcc_bus_req_s busReq,
  output logic [7:0] regRdata_q,
  input wire logic [3:0] chanIsCompare,
  input wire logic [3:0] ch3CompareMask,
  input wire logic [3:0][15:0] compareValue,
  input wire logic [3:0] captureRead,
  input wire logic [3:0] compareWrite,
  input wire logic counterAccess,
  input wire logic [3:0] timerChannelPinIn,
  output logic [3:0] compareOutputLine_q,
  output logic [3:0] timerChannelPinOe_q,
  output logic [3:0] captureStrobe_q,
  output tcc_count_t counter_q,
  output logic [3:0] chanIrq_q,
  output logic ovfIrq_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decoded fields

  logic [7:0] sysCtlOne_q;
  logic [7:0] outCtl_q;
  logic [7:0] edgeCtl_q;
  logic [7:0] chanIe_q;
  logic [7:0] sysCtlTwo_q;
  logic [3:0] eventFlag_q;
  logic ovfFlag_q;
  logic [2:0] prescActive_q;
  logic [6:0] prescCnt_q;
  logic [3:0] pinPrev_q;
  logic [6:0] prescMask;
  logic timerRunEnable;
  logic fastFlagClear;
  logic overflowIrqEnable;
  logic counterResetOnCh3;
  logic [2:0] prescaleSelect;
  logic tick;
  logic ch3Reset;
  logic setOvf;
  logic [3:0] cmpHit;
  logic [3:0] capHit;
  logic [7:0] rdVal;
  logic wrFlags;
  logic wrOvf;

  assign timerRunEnable = sysCtlOne_q[`TCC_BIT_RUN_ENABLE];
  assign fastFlagClear = sysCtlOne_q[`TCC_BIT_FAST_FLAG_CLEAR];
  assign overflowIrqEnable = sysCtlTwo_q[`TCC_BIT_OVERFLOW_IRQ_ENABLE];
  assign counterResetOnCh3 = sysCtlTwo_q[`TCC_BIT_COUNTER_RESET_ON_CH3];
  assign prescaleSelect = sysCtlTwo_q[2:0];
  assign wrFlags = busReq.wr && (busReq.addr == `TCC_OFF_CHANNEL_EVENT_FLAGS);
  assign wrOvf = busReq.wr && (busReq.addr == `TCC_OFF_OVERFLOW_FLAG);

  ////////////////////////////////////////////////////////////////////////////////
  // Control register writes

  // Write masks keep unimplemented bits at zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sysCtlOne_q <= `TCC_RESET_REG;
      outCtl_q <= `TCC_RESET_REG;
      edgeCtl_q <= `TCC_RESET_REG;
      chanIe_q <= `TCC_RESET_REG;
      sysCtlTwo_q <= `TCC_RESET_REG;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        `TCC_OFF_SYS_CONTROL_ONE: sysCtlOne_q <= busReq.wdata & `TCC_MASK_SYS_CONTROL_ONE;
        `TCC_OFF_COMPARE_OUTPUT_CONTROL: outCtl_q <= busReq.wdata;
        `TCC_OFF_CAPTURE_EDGE_CONTROL: edgeCtl_q <= busReq.wdata;
        `TCC_OFF_CHANNEL_INTERRUPT_ENABLE: chanIe_q <= busReq.wdata & `TCC_MASK_CHANNELS;
        `TCC_OFF_SYSTEM_CONTROL_TWO: sysCtlTwo_q <= busReq.wdata & `TCC_MASK_SYSTEM_CONTROL_TWO;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler

  // Divide by 2^select: tick when the low select bits of the stage counter are zero
  assign prescMask = `TCC_PRESC_FULL >> (3'h7 - prescActive_q);
  assign tick = timerRunEnable && ((prescCnt_q & prescMask) == `TCC_PRESC_ZERO);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescCnt_q <= `TCC_PRESC_ZERO;
    end else if (!timerRunEnable) begin
      prescCnt_q <= `TCC_PRESC_ZERO;
    end else begin
      prescCnt_q <= prescCnt_q + 7'h01;
    end
  end

  // Switching mid-count would give one short or long period, so wait for alignment
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescActive_q <= 3'h0;
    end else if (prescCnt_q == `TCC_PRESC_ZERO) begin
      prescActive_q <= prescaleSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running counter and overflow

  assign ch3Reset = counterResetOnCh3 && cmpHit[3];
  assign setOvf = tick && (counter_q == `TCC_COUNT_MAX) && !ch3Reset;

  // A channel 3 value of zero matches on every tick, so the counter sticks at zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      counter_q <= `TCC_COUNT_ZERO;
    end else if (tick) begin
      if (ch3Reset) begin
        counter_q <= `TCC_COUNT_ZERO;
      end else begin
        counter_q <= counter_q + 16'h0001;
      end
    end
  end

  // Set wins over every clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovfFlag_q <= 1'b0;
    end else if (setOvf) begin
      ovfFlag_q <= 1'b1;
    end else if (wrOvf && busReq.wdata[`TCC_BIT_OVERFLOW_FLAG]) begin
      ovfFlag_q <= 1'b0;
    end else if (fastFlagClear && counterAccess) begin
      ovfFlag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel compare action, capture edge detect and event flag

  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_chan
      tcc_action_e action;
      tcc_edge_e edgeSel;
      logic rise;
      logic fall;

      assign action = tcc_action_e'({outCtl_q[2*n+1], outCtl_q[2*n]});
      assign edgeSel = tcc_edge_e'({edgeCtl_q[2*n+1], edgeCtl_q[2*n]});
      assign rise = timerChannelPinIn[n] && !pinPrev_q[n];
      assign fall = !timerChannelPinIn[n] && pinPrev_q[n];
      assign cmpHit[n] = tick && chanIsCompare[n] && (counter_q == compareValue[n]);

      always_comb begin
        unique case (edgeSel)
          EDGE_NONE: capHit[n] = 1'b0;
          EDGE_RISE: capHit[n] = timerRunEnable && !chanIsCompare[n] && rise;
          EDGE_FALL: capHit[n] = timerRunEnable && !chanIsCompare[n] && fall;
          EDGE_ANY: capHit[n] = timerRunEnable && !chanIsCompare[n] && (rise || fall);
        endcase
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          pinPrev_q[n] <= 1'b0;
        end else begin
          pinPrev_q[n] <= timerChannelPinIn[n];
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          compareOutputLine_q[n] <= 1'b0;
        end else if (cmpHit[n] && !ch3CompareMask[n]) begin
          unique case (action)
            ACT_OFF: compareOutputLine_q[n] <= compareOutputLine_q[n];
            ACT_TOGGLE: compareOutputLine_q[n] <= !compareOutputLine_q[n];
            ACT_CLEAR: compareOutputLine_q[n] <= 1'b0;
            ACT_SET: compareOutputLine_q[n] <= 1'b1;
          endcase
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          timerChannelPinOe_q[n] <= 1'b0;
        end else begin
          timerChannelPinOe_q[n] <= (action != ACT_OFF);
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          eventFlag_q[n] <= 1'b0;
        end else if (cmpHit[n] || capHit[n]) begin
          eventFlag_q[n] <= 1'b1;
        end else if (wrFlags && busReq.wdata[n]) begin
          eventFlag_q[n] <= 1'b0;
        end else if (fastFlagClear && ((captureRead[n] && !chanIsCompare[n]) ||
                                       (compareWrite[n] && chanIsCompare[n]))) begin
          eventFlag_q[n] <= 1'b0;
        end
      end

      a_compare_action: assert property (@(posedge core_clk) disable iff (!nrst)
        cmpHit[n] && !ch3CompareMask[n] && action == ACT_TOGGLE
        |=> compareOutputLine_q[n] != $past(compareOutputLine_q[n]))
        else $error("toggle action did not toggle");
      a_mask_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
        ch3CompareMask[n] |=> $stable(compareOutputLine_q[n]))
        else $error("masked channel changed its line");
      a_pin_enable: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 timerChannelPinOe_q[n] == ($past(outCtl_q[2*n+1]) || $past(outCtl_q[2*n])))
        else $error("pin enable does not follow action code");
      a_flag_fast: assert property (@(posedge core_clk) disable iff (!nrst)
        fastFlagClear && !cmpHit[n] && !capHit[n] &&
        ((captureRead[n] && !chanIsCompare[n]) || (compareWrite[n] && chanIsCompare[n]))
        |=> !eventFlag_q[n])
        else $error("fast clear did not clear channel flag");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      captureStrobe_q <= 4'h0;
    end else begin
      captureStrobe_q <= capHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chanIrq_q <= 4'h0;
      ovfIrq_q <= 1'b0;
    end else begin
      chanIrq_q <= eventFlag_q & chanIe_q[3:0];
      ovfIrq_q <= ovfFlag_q && overflowIrqEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency, zero when idle or unmapped

  always_comb begin
    unique case (busReq.addr)
      `TCC_OFF_SYS_CONTROL_ONE: rdVal = sysCtlOne_q;
      `TCC_OFF_COMPARE_OUTPUT_CONTROL: rdVal = outCtl_q;
      `TCC_OFF_CAPTURE_EDGE_CONTROL: rdVal = edgeCtl_q;
      `TCC_OFF_CHANNEL_INTERRUPT_ENABLE: rdVal = chanIe_q;
      `TCC_OFF_SYSTEM_CONTROL_TWO: rdVal = sysCtlTwo_q;
      `TCC_OFF_CHANNEL_EVENT_FLAGS: rdVal = {4'h0, eventFlag_q};
      `TCC_OFF_OVERFLOW_FLAG: rdVal = {ovfFlag_q, 7'h00};
      default: rdVal = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_q <= 8'h00;
    end else if (busReq.rd) begin
      regRdata_q <= rdVal;
    end else begin
      regRdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_prescale_sync: assert property (@(posedge core_clk) disable iff (!nrst)
    prescActive_q != $past(prescActive_q) |-> $past(prescCnt_q) == `TCC_PRESC_ZERO)
    else $error("prescale changed off the aligned point");
  a_prescale_div2: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && prescActive_q != 3'h0 ##1 prescActive_q != 3'h0 |-> !tick)
    else $error("divided clock ticked twice in a row");
  a_timer_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !timerRunEnable |=> $stable(counter_q))
    else $error("counter moved while timer disabled");
  a_counter_reset: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && counterResetOnCh3 && cmpHit[3] |=> counter_q == `TCC_COUNT_ZERO)
    else $error("channel 3 compare did not clear counter");
  a_counter_runs: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && !ch3Reset |=> counter_q == $past(counter_q) + 16'h0001)
    else $error("counter did not advance on tick");
  a_counter_stuck: assert property (@(posedge core_clk) disable iff (!nrst)
    counterResetOnCh3 && chanIsCompare[3] && compareValue[3] == `TCC_COUNT_ZERO &&
    counter_q == `TCC_COUNT_ZERO && tick |=> counter_q == `TCC_COUNT_ZERO)
    else $error("counter left zero with zero channel 3 value");
  a_no_ovf_modulus: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && ch3Reset && counter_q == `TCC_COUNT_MAX && !ovfFlag_q |=> !ovfFlag_q)
    else $error("overflow set on modulus reset");
  a_ovf_set: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && !counterResetOnCh3 && counter_q == `TCC_COUNT_MAX |=> ovfFlag_q)
    else $error("wrap did not set overflow flag");
  a_ovf_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    wrOvf && busReq.wdata[`TCC_BIT_OVERFLOW_FLAG] && !setOvf |=> !ovfFlag_q)
    else $error("overflow flag not cleared by write");
  a_ovf_fast: assert property (@(posedge core_clk) disable iff (!nrst)
    fastFlagClear && counterAccess && !setOvf |=> !ovfFlag_q)
    else $error("counter access did not clear overflow flag");
  a_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (cmpHit | capHit) != 4'h0 |=> (eventFlag_q & $past(cmpHit | capHit)) == $past(cmpHit | capHit))
    else $error("event did not set its flag");
  a_flag_w1c: assert property (@(posedge core_clk) disable iff (!nrst)
    wrFlags && (cmpHit | capHit) == 4'h0 && !fastFlagClear
    |=> eventFlag_q == ($past(eventFlag_q) & ~$past(busReq.wdata[3:0])))
    else $error("flag write did not clear exactly the ones");
  a_chan_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    chanIe_q[3:0] == 4'h0 ##1 chanIe_q[3:0] == 4'h0 |-> chanIrq_q == 4'h0)
    else $error("channel request without enable");
  a_ovf_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    ovfFlag_q && overflowIrqEnable ##1 ovfFlag_q && overflowIrqEnable |-> ovfIrq_q)
    else $error("overflow request missing");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    busReq.rd && busReq.addr == `TCC_OFF_CHANNEL_EVENT_FLAGS |=> regRdata_q[7:4] == 4'h0)
    else $error("reserved flag bits read nonzero");

endmodule

// ==== tcc_mcu_model.sv ====
// Bus-side model of the microcontroller core issuing register accesses
`timescale 1ns/1ns
module tcc_mcu_model import tcc_pkg::*; (
  input wire logic core_clk,
  input wire logic [7:0] regRdata_q,
  output tcc_bus_req_s busReq
);
  initial begin
    busReq = '{wr: 1'b0, rd: 1'b0, addr: 8'h3C, wdata: 8'hA5};
  end
  ////////////////////////////////////////////////////////////////
  // Idle lines flip so a stale address never passes for a request
  task automatic idle();
    busReq.wr = 1'b0;
    busReq.rd = 1'b0;
    busReq.addr = ~busReq.addr;
    busReq.wdata = ~busReq.wdata;
  endtask
  // One-cycle strobe, held across the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    idle();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: busReq.wdata};
    @(negedge core_clk);
    d = regRdata_q;
    idle();
  endtask
endmodule

// ==== timer_capture_compare_control_tb.sv ====
// Self-checking testbench of the timer control block
`timescale 1ns/1ns
module timer_capture_compare_control_tb import tcc_pkg::*;;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
  } tcc_row_s;
  logic core_clk;
  logic nrst;
  tcc_bus_req_s busReq;
  logic [7:0] regRdata_q;
  logic [3:0] chanIsCompare;
  logic [3:0] ch3CompareMask;
  logic [3:0][15:0] compareValue;
  logic [3:0] captureRead;
  logic [3:0] compareWrite;
  logic counterAccess;
  logic [3:0] timerChannelPinIn;
  logic [3:0] compareOutputLine_q;
  logic [3:0] timerChannelPinOe_q;
  logic [3:0] captureStrobe_q;
  tcc_count_t counter_q;
  logic [3:0] chanIrq_q;
  logic ovfIrq_q;
  int miscompares = 0;
  int num_checks = 0;
  tcc_count_t c0;
  tcc_row_s rows[9] = '{'{8'hC6, 8'hFF, 8'h90}, '{8'hC8, 8'hA5, 8'hA5}, '{8'hC9, 8'h5A, 8'h5A},
    '{8'hCA, 8'hFF, 8'h0F}, '{8'hCB, 8'hFF, 8'h8F}, '{8'hCC, 8'hFF, 8'h00}, '{8'hCD, 8'hFF, 8'h00},
    '{8'hC7, 8'hFF, 8'h00}, '{8'hC5, 8'hFF, 8'h00}};

  tcc_timer_ctrl tcc_timer_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .busReq(busReq),
    .regRdata_q(regRdata_q), .chanIsCompare(chanIsCompare), .ch3CompareMask(ch3CompareMask),
    .compareValue(compareValue), .captureRead(captureRead), .compareWrite(compareWrite),
    .counterAccess(counterAccess), .timerChannelPinIn(timerChannelPinIn),
    .compareOutputLine_q(compareOutputLine_q), .timerChannelPinOe_q(timerChannelPinOe_q),
    .captureStrobe_q(captureStrobe_q), .counter_q(counter_q), .chanIrq_q(chanIrq_q),
    .ovfIrq_q(ovfIrq_q));
  tcc_mcu_model tcc_mcu_model_inst (.core_clk(core_clk), .regRdata_q(regRdata_q), .busReq(busReq));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tcc_mcu_model_inst.wr_reg(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    tcc_mcu_model_inst.rd_reg(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  // Strobes are ORed over a few cycles, so latency choices do not matter
  task automatic edges(input logic [3:0] pins, input logic [3:0] exp);
    logic [3:0] acc;
    acc = 4'h0;
    timerChannelPinIn = pins;
    repeat (4) begin
      @(negedge core_clk);
      acc = acc | captureStrobe_q;
    end
    chk(acc, exp);
  endtask
  task automatic pulse(input logic [3:0] cr, input logic [3:0] cw, input logic ca);
    @(negedge core_clk);
    captureRead = cr;
    compareWrite = cw;
    counterAccess = ca;
    @(negedge core_clk);
    captureRead = 4'h0;
    compareWrite = 4'h0;
    counterAccess = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    chanIsCompare = 4'h0;
    ch3CompareMask = 4'h0;
    compareValue = '0;
    captureRead = 4'h0;
    compareWrite = 4'h0;
    counterAccess = 1'b0;
    timerChannelPinIn = 4'h0;
    do_reset();
    chk({compareOutputLine_q, timerChannelPinOe_q, captureStrobe_q, chanIrq_q}, 16'h0000);
    chk(counter_q, 16'h0000);
    foreach (rows[i]) begin
      rdc(rows[i].addr, 8'h00);
      wr(rows[i].addr, rows[i].wd);
      rdc(rows[i].addr, rows[i].exp);
    end
    $display("test registers done");
    // Compare: ch0 toggle, ch1 low, ch2 high but masked, ch3 off
    do_reset();
    chanIsCompare = 4'hF;
    compareValue = {4{16'h0010}};
    ch3CompareMask = 4'h4;
    wr(8'hC8, 8'h39);
    repeat (2) @(negedge core_clk);
    chk(timerChannelPinOe_q, 4'h7);
    wr(8'hCA, 8'h05);
    wr(8'hC6, 8'h80);
    repeat (40) @(negedge core_clk);
    chk(compareOutputLine_q, 4'h1);
    chk(chanIrq_q, 4'h5);
    rdc(8'hCC, 8'h0F);
    wr(8'hCC, 8'h03);
    rdc(8'hCC, 8'h0C);
    wr(8'hC6, 8'h90);
    pulse(4'h8, 4'h4, 1'b0);
    rdc(8'hCC, 8'h08);
    $display("test compare done");
    // Counter reset on channel 3
    do_reset();
    compareValue[3] = 16'h0000;
    wr(8'hCB, 8'h08);
    wr(8'hC6, 8'h80);
    repeat (20) @(negedge core_clk);
    chk(counter_q, 16'h0000);
    compareValue[3] = 16'h0020;
    c0 = 16'h0000;
    repeat (100) begin
      @(negedge core_clk);
      if (counter_q > c0) c0 = counter_q;
    end
    chk(c0, 16'h0020);
    $display("test counter reset done");
    // Capture edges: ch0 rise, ch1 fall, ch2 both, ch3 off
    do_reset();
    chanIsCompare = 4'h0;
    wr(8'hC9, 8'h39);
    wr(8'hC6, 8'h80);
    edges(4'hF, 4'h5);
    rdc(8'hCC, 8'h05);
    wr(8'hCC, 8'h0F);
    edges(4'h0, 4'h6);
    rdc(8'hCC, 8'h06);
    wr(8'hC6, 8'h90);
    pulse(4'h2, 4'h4, 1'b0);
    rdc(8'hCC, 8'h04);
    $display("test capture done");
    // Prescaler and run enable
    c0 = counter_q;
    repeat (10) @(negedge core_clk);
    chk(counter_q - c0, 16'h000A);
    wr(8'hCB, 8'h02);
    repeat (140) @(negedge core_clk);
    c0 = counter_q;
    repeat (32) @(negedge core_clk);
    chk(counter_q - c0, 16'h0008);
    wr(8'hC6, 8'h00);
    c0 = counter_q;
    repeat (10) @(negedge core_clk);
    chk(counter_q, c0);
    $display("test prescaler done");
    // Overflow flag and its request
    do_reset();
    wr(8'hC6, 8'h80);
    for (int i = 0; i < 70000 && counter_q !== 16'hFFFF; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    rdc(8'hCD, 8'h80);
    chk(ovfIrq_q, 1'b0);
    wr(8'hCB, 8'h80);
    repeat (2) @(negedge core_clk);
    chk(ovfIrq_q, 1'b1);
    pulse(4'h0, 4'h0, 1'b1);
    rdc(8'hCD, 8'h80);
    wr(8'hCD, 8'h80);
    rdc(8'hCD, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(ovfIrq_q, 1'b0);
    $display("test overflow done");
    tally_and_finish();
  end
endmodule
